// File: hw/fpc_top.sv
// Flash programming control: command interpreter, FIFO and mode register.
//
// Overview of operation
// - Programmer starts every exchange; device answers each command, never initiates.
// - Batch verify compares whole array with supplied bytes, answers match result.
// - Batch erase clears the whole array to the erased value.
// - Batch blank check scans whole array, answers whether all bytes erased.
// - High-speed write takes address and count, programs bytes, verifies each.
// - Successive write continues after last high-speed write byte, verifies.
// - Status read returns the current operation status byte.
// - Frequency setting is stored and scales all later wait times.
// - Erase time setting is stored and used by later batch erases.
// - Write time setting is stored and used by later byte programming.
// - Baud rate setting changes the serial rate selection output.
// - Signature command returns the stored identification bytes.
// - Reset command abandons any command state and returns to idle.
// - Valid command or data gets acknowledge; illegal ones get refusal.
// - Select field decodes normal fetch, firmware call, firmware fetch.
// - Firmware-fetch select only settable by firmware; value 10 prohibited.
// - Write/erase-disable bit zero allows, one forbids flash changes.
// - Mode-pin level bit is read-only and mirrors the mode pin.
// - Flash changes only when disable bit is 0 and pin level is 1.
// - Reset loads mode control with 08H user mode, 0CH on-board mode.
// - Mode control accepts writes only via protected sequence, bit or byte.
// - Sequence deviation keeps register and sets sticky protection error.
// - In on-board programming mode the select field is ignored.

module fpc_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [PW:0] wr;
		logic [PW:0] rd;
	} fpc_fifo_t;

	fpc_fifo_t        st_reg;
	fpc_fifo_t        st_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	assign in_ready  = (st_reg.wr - st_reg.rd) != (PW + 1)'(DEPTH);
	assign out_valid = st_reg.wr != st_reg.rd;
	assign out_data  = mem[st_reg.rd[PW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		st_next = st_reg;
		if (push)
			st_next.wr = st_reg.wr + 1'b1;
		if (pop)
			st_next.rd = st_reg.rd + 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem[st_reg.wr[PW-1:0]] <= in_data;
	end
endmodule : fpc_fifo

module fpc_top #(
	parameter int          FLASH_DEPTH = 256,
	parameter int          FIFO_DEPTH  = 16,
	parameter logic [23:0] SIG_CODE    = 24'h5A3C01
) (
	input  wire logic        CLK_SYS,
	input  wire logic        SYS_RST,
	input  wire logic        RX_VALID,
	output logic             RX_READY,
	input  wire logic [7:0]  RX_DATA,
	input  wire logic        RX_START,
	output logic             RSP_VALID,
	input  wire logic        RSP_READY,
	output logic      [7:0]  RSP_DATA,
	output logic      [2:0]  BAUD_SEL,
	output logic             BUSY,
	input  wire logic        ST_VALID,
	input  wire logic [15:0] ST_ADDR,
	input  wire logic [7:0]  ST_DATA,
	input  wire logic [15:0] LD_ADDR,
	output logic      [7:0]  LD_DATA,
	input  wire logic        FW_ACTIVE,
	input  wire logic        FLASH_MODE_PIN,
	input  wire logic        ONBOARD_MODE,
	output logic             FLASH_WE_EN,
	output logic             FETCH_USER,
	output logic             FW_CALL_EN,
	output logic             FW_FETCH
);
	localparam int AW = $clog2(FLASH_DEPTH);

	typedef struct packed {
		fpc_pkg::fpc_state_t st;
		logic [15:0]         ptr;
		logic [7:0]          cnt;
		logic [15:0]         wait_cnt;
		logic [7:0]          wbyte;
		logic [15:0]         arg;
		logic [1:0]          argn;
		logic [7:0]          cmd;
		logic                err;
		logic [15:0]         nxt;
		logic                nxt_ok;
		logic [7:0]          osc;
		logic [7:0]          etime;
		logic [7:0]          wtime;
		logic [2:0]          baud;
		logic                rsp_v;
		logic [7:0]          rsp_d;
		logic [1:0]          more;
		logic                last_nak;
		logic                wed;
		logic [1:0]          sel;
		logic                pin_lvl;
		fpc_pkg::fpc_prot_t  prot;
		logic [7:0]          prot_val;
		logic                prot_err;
		logic [7:0]          rd_d;
	} fpc_regs_t;

	fpc_regs_t   r_reg;
	fpc_regs_t   r_next;
	logic [7:0]  mem [FLASH_DEPTH];
	logic        f_valid;
	logic        f_take;
	logic [8:0]  f_data;
	logic [7:0]  b;
	logic        s;
	logic [7:0]  cur;
	logic        we_ok;
	logic        last_loc;
	logic        mem_we;
	logic [7:0]  mem_wd;
	logic [7:0]  status;
	logic        err_set;
	logic        err_clr;
	logic        range_bad;

	fpc_fifo #(
		.WIDTH (9),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (CLK_SYS),
		.rst       (SYS_RST),
		.in_valid  (RX_VALID),
		.in_ready  (RX_READY),
		.in_data   ({RX_START, RX_DATA}),
		.out_valid (f_valid),
		.out_ready (f_take),
		.out_data  (f_data)
	);

	assign b        = f_data[7:0];
	assign s        = f_data[8];
	assign cur      = mem[r_reg.ptr[AW-1:0]];
	assign last_loc = r_reg.ptr == 16'(FLASH_DEPTH - 1);
	assign we_ok    = !r_reg.wed && r_reg.pin_lvl;
	assign status   = {4'h0, ONBOARD_MODE, r_reg.nxt_ok, we_ok,
		r_reg.last_nak};
	assign range_bad = ({1'b0, r_reg.arg} + {9'h000, b}) >
		17'(FLASH_DEPTH);

	always_comb
	begin
		r_next  = r_reg;
		f_take  = 1'b0;
		mem_we  = 1'b0;
		mem_wd  = fpc_pkg::FPC_ERASED;
		err_set = 1'b0;
		err_clr = 1'b0;
		r_next.pin_lvl = FLASH_MODE_PIN;

		// Multi-byte answers stream out behind the acknowledge.
		if (r_reg.rsp_v && RSP_READY)
		begin
			if (r_reg.more != 2'h0)
			begin
				r_next.more = r_reg.more - 2'h1;
				if (r_reg.cmd == fpc_pkg::FPC_CMD_STATUS)
					r_next.rsp_d = status;
				else
					case (r_reg.more)
						2'h3: r_next.rsp_d = SIG_CODE[23:16];
						2'h2: r_next.rsp_d = SIG_CODE[15:8];
						default: r_next.rsp_d = SIG_CODE[7:0];
					endcase
			end
			else
				r_next.rsp_v = 1'b0;
		end

		if (r_reg.st != fpc_pkg::FPC_IDLE && f_valid && s)
			r_next.st = fpc_pkg::FPC_IDLE;
		else
			case (r_reg.st)
				fpc_pkg::FPC_IDLE:
				begin
					if (f_valid && !r_reg.rsp_v)
					begin
						f_take       = 1'b1;
						r_next.cmd   = b;
						r_next.ptr   = 16'h0000;
						r_next.err   = 1'b0;
						r_next.argn  = 2'h0;
						r_next.rsp_v = 1'b1;
						r_next.rsp_d = fpc_pkg::FPC_RSP_ACK;
						if (!s)
							r_next.rsp_d = fpc_pkg::FPC_RSP_NAK;
						else
							case (b)
								fpc_pkg::FPC_CMD_VERIFY:
								begin
									r_next.rsp_v = 1'b0;
									r_next.st    = fpc_pkg::FPC_VERIFY;
								end
								fpc_pkg::FPC_CMD_ERASE:
								begin
									if (!we_ok)
										r_next.rsp_d = fpc_pkg::FPC_RSP_NAK;
									else
									begin
										r_next.rsp_v    = 1'b0;
										r_next.wait_cnt = {8'h00, r_reg.etime} *
											{8'h00, r_reg.osc};
										r_next.st       = fpc_pkg::FPC_EWAIT;
									end
								end
								fpc_pkg::FPC_CMD_BLANK:
								begin
									r_next.rsp_v = 1'b0;
									r_next.st    = fpc_pkg::FPC_BLANK;
								end
								fpc_pkg::FPC_CMD_HS_WRITE,
								fpc_pkg::FPC_CMD_SUCC_WRITE,
								fpc_pkg::FPC_CMD_OSC,
								fpc_pkg::FPC_CMD_ERASE_TIME,
								fpc_pkg::FPC_CMD_WRITE_TIME,
								fpc_pkg::FPC_CMD_BAUD:
								begin
									r_next.rsp_v = 1'b0;
									r_next.st    = fpc_pkg::FPC_ARG;
								end
								fpc_pkg::FPC_CMD_STATUS:
									r_next.more = 2'h1;
								fpc_pkg::FPC_CMD_SIGNATURE:
									r_next.more = fpc_pkg::FPC_SIG_BYTES;
								fpc_pkg::FPC_CMD_RESET:
									r_next.more = 2'h0;
								default:
									r_next.rsp_d = fpc_pkg::FPC_RSP_NAK;
							endcase
					end
				end
				fpc_pkg::FPC_ARG:
				begin
					if (f_valid)
					begin
						f_take      = 1'b1;
						r_next.arg  = {r_reg.arg[7:0], b};
						r_next.argn = r_reg.argn + 2'h1;
						if (r_reg.cmd != fpc_pkg::FPC_CMD_HS_WRITE ||
							r_reg.argn == 2'h2)
						begin
							r_next.st    = fpc_pkg::FPC_IDLE;
							r_next.rsp_v = 1'b1;
							r_next.rsp_d = fpc_pkg::FPC_RSP_ACK;
							case (r_reg.cmd)
								fpc_pkg::FPC_CMD_OSC:
									r_next.osc = b;
								fpc_pkg::FPC_CMD_ERASE_TIME:
									r_next.etime = b;
								fpc_pkg::FPC_CMD_WRITE_TIME:
									r_next.wtime = b;
								fpc_pkg::FPC_CMD_BAUD:
									r_next.baud = b[2:0];
								fpc_pkg::FPC_CMD_HS_WRITE:
								begin
									r_next.ptr = r_reg.arg;
									r_next.err = range_bad || !we_ok;
								end
								default:
								begin
									r_next.ptr = r_reg.nxt;
									r_next.err = !r_reg.nxt_ok || !we_ok ||
										(({1'b0, r_reg.nxt} + {9'h000, b}) >
										17'(FLASH_DEPTH));
								end
							endcase
							if (b == 8'h00)
							begin
								r_next.rsp_d    = fpc_pkg::FPC_RSP_NAK;
								r_next.osc      = r_reg.osc;
								r_next.etime    = r_reg.etime;
								r_next.wtime    = r_reg.wtime;
								r_next.last_nak = 1'b1;
							end
							else if (r_reg.cmd == fpc_pkg::FPC_CMD_BAUD &&
								b > fpc_pkg::FPC_BAUD_MAX)
							begin
								r_next.rsp_d    = fpc_pkg::FPC_RSP_NAK;
								r_next.baud     = r_reg.baud;
								r_next.last_nak = 1'b1;
							end
							else if (r_reg.cmd == fpc_pkg::FPC_CMD_HS_WRITE ||
								r_reg.cmd == fpc_pkg::FPC_CMD_SUCC_WRITE)
							begin
								r_next.rsp_v = 1'b0;
								r_next.cnt   = b;
								r_next.st    = fpc_pkg::FPC_WDATA;
							end
						end
					end
				end
				fpc_pkg::FPC_VERIFY:
				begin
					if (f_valid)
					begin
						f_take     = 1'b1;
						r_next.ptr = r_reg.ptr + 16'h0001;
						if (cur != b)
							r_next.err = 1'b1;
						if (last_loc)
						begin
							r_next.st       = fpc_pkg::FPC_IDLE;
							r_next.rsp_v    = 1'b1;
							r_next.last_nak = r_reg.err || cur != b;
							r_next.rsp_d    = (r_reg.err || cur != b) ?
								fpc_pkg::FPC_RSP_NAK : fpc_pkg::FPC_RSP_ACK;
						end
					end
				end
				fpc_pkg::FPC_WDATA:
				begin
					if (f_valid)
					begin
						f_take          = 1'b1;
						r_next.wbyte    = b;
						r_next.wait_cnt = {8'h00, r_reg.wtime} *
							{8'h00, r_reg.osc};
						r_next.st       = fpc_pkg::FPC_WWAIT;
						if (r_reg.err)
							r_next.st = fpc_pkg::FPC_WCHECK;
					end
				end
				fpc_pkg::FPC_WWAIT:
				begin
					r_next.wait_cnt = r_reg.wait_cnt - 16'h0001;
					if (r_reg.wait_cnt == 16'h0000)
					begin
						mem_we    = we_ok;
						mem_wd    = r_reg.wbyte;
						r_next.st = fpc_pkg::FPC_WCHECK;
					end
				end
				fpc_pkg::FPC_WCHECK:
				begin
					r_next.ptr = r_reg.ptr + 16'h0001;
					r_next.cnt = r_reg.cnt - 8'h01;
					r_next.st  = fpc_pkg::FPC_WDATA;
					if (cur != r_reg.wbyte)
						r_next.err = 1'b1;
					if (r_reg.cnt == 8'h01)
					begin
						r_next.st       = fpc_pkg::FPC_IDLE;
						r_next.rsp_v    = 1'b1;
						r_next.nxt      = r_reg.ptr + 16'h0001;
						r_next.nxt_ok   = !r_reg.err && cur == r_reg.wbyte;
						r_next.last_nak = !r_next.nxt_ok;
						r_next.rsp_d    = r_next.nxt_ok ?
							fpc_pkg::FPC_RSP_ACK : fpc_pkg::FPC_RSP_NAK;
					end
				end
				fpc_pkg::FPC_EWAIT:
				begin
					r_next.wait_cnt = r_reg.wait_cnt - 16'h0001;
					if (r_reg.wait_cnt == 16'h0000)
						r_next.st = fpc_pkg::FPC_ECLEAR;
				end
				fpc_pkg::FPC_ECLEAR:
				begin
					mem_we     = we_ok;
					r_next.ptr = r_reg.ptr + 16'h0001;
					if (last_loc)
					begin
						r_next.st       = fpc_pkg::FPC_IDLE;
						r_next.nxt_ok   = 1'b0;
						r_next.rsp_v    = 1'b1;
						r_next.last_nak = !we_ok;
						r_next.rsp_d    = we_ok ?
							fpc_pkg::FPC_RSP_ACK : fpc_pkg::FPC_RSP_NAK;
					end
				end
				fpc_pkg::FPC_BLANK:
				begin
					r_next.ptr = r_reg.ptr + 16'h0001;
					if (cur != fpc_pkg::FPC_ERASED)
						r_next.err = 1'b1;
					if (last_loc)
					begin
						r_next.st       = fpc_pkg::FPC_IDLE;
						r_next.rsp_v    = 1'b1;
						r_next.last_nak = r_next.err;
						r_next.rsp_d    = r_next.err ?
							fpc_pkg::FPC_RSP_NAK : fpc_pkg::FPC_RSP_ACK;
					end
				end
				default:
					r_next.st = fpc_pkg::FPC_IDLE;
			endcase

		// Protected store sequence on the mode control register.
		if (ST_VALID)
			case (r_reg.prot)
				fpc_pkg::FPC_P_IDLE:
				begin
					if (ST_ADDR == fpc_pkg::FPC_ADDR_PROT_CMD)
					begin
						if (ST_DATA == fpc_pkg::FPC_PROT_KEY)
							r_next.prot = fpc_pkg::FPC_P_KEY;
						else
							err_set = 1'b1;
					end
					else if (ST_ADDR == fpc_pkg::FPC_ADDR_MODE_CTL)
						err_set = 1'b1;
					else if (ST_ADDR == fpc_pkg::FPC_ADDR_PROT_STAT)
						err_clr = !ST_DATA[fpc_pkg::FPC_BIT_PERR];
				end
				fpc_pkg::FPC_P_KEY:
				begin
					r_next.prot     = fpc_pkg::FPC_P_VALUE;
					r_next.prot_val = ST_DATA;
					if (ST_ADDR != fpc_pkg::FPC_ADDR_MODE_CTL)
					begin
						err_set     = 1'b1;
						r_next.prot = fpc_pkg::FPC_P_IDLE;
					end
				end
				fpc_pkg::FPC_P_VALUE:
				begin
					r_next.prot = fpc_pkg::FPC_P_INVERSE;
					if (ST_ADDR != fpc_pkg::FPC_ADDR_MODE_CTL ||
						ST_DATA != ~r_reg.prot_val)
					begin
						err_set     = 1'b1;
						r_next.prot = fpc_pkg::FPC_P_IDLE;
					end
				end
				default:
				begin
					r_next.prot = fpc_pkg::FPC_P_IDLE;
					if (ST_ADDR != fpc_pkg::FPC_ADDR_MODE_CTL ||
						ST_DATA != r_reg.prot_val)
						err_set = 1'b1;
					else
					begin
						r_next.wed = ST_DATA[fpc_pkg::FPC_BIT_WED];
						if (ST_DATA[1:0] != fpc_pkg::FPC_SEL_BAD &&
							(ST_DATA[1:0] != fpc_pkg::FPC_SEL_FW_FETCH ||
							FW_ACTIVE))
							r_next.sel = ST_DATA[1:0];
					end
				end
			endcase
		r_next.prot_err = (r_reg.prot_err && !err_clr) || err_set;

		case (LD_ADDR)
			fpc_pkg::FPC_ADDR_MODE_CTL:
				r_next.rd_d = {4'h0, r_reg.wed, r_reg.pin_lvl, r_reg.sel};
			fpc_pkg::FPC_ADDR_PROT_STAT:
				r_next.rd_d = {7'h00, r_reg.prot_err};
			default:
				r_next.rd_d = 8'h00;
		endcase
	end

	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			r_reg          <= '0;
			r_reg.st       <= fpc_pkg::FPC_IDLE;
			r_reg.prot     <= fpc_pkg::FPC_P_IDLE;
			r_reg.osc      <= fpc_pkg::FPC_OSC_RESET;
			r_reg.etime    <= fpc_pkg::FPC_ETIME_RESET;
			r_reg.wtime    <= fpc_pkg::FPC_WTIME_RESET;
			r_reg.baud     <= fpc_pkg::FPC_BAUD_RESET;
			r_reg.wed      <= fpc_pkg::FPC_MODE_CTL_RESET[fpc_pkg::FPC_BIT_WED];
			r_reg.sel      <= fpc_pkg::FPC_MODE_CTL_RESET[1:0];
			r_reg.prot_err <= fpc_pkg::FPC_PROT_STAT_RST[fpc_pkg::FPC_BIT_PERR];
		end
		else
			r_reg <= r_next;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (mem_we)
			mem[r_reg.ptr[AW-1:0]] <= mem_wd;
	end

	assign RSP_VALID   = r_reg.rsp_v;
	assign RSP_DATA    = r_reg.rsp_d;
	assign BAUD_SEL    = r_reg.baud;
	assign BUSY        = r_reg.st != fpc_pkg::FPC_IDLE;
	assign LD_DATA     = r_reg.rd_d;
	assign FLASH_WE_EN = we_ok;
	assign FETCH_USER  = ONBOARD_MODE ||
		r_reg.sel != fpc_pkg::FPC_SEL_FW_FETCH;
	assign FW_CALL_EN  = !ONBOARD_MODE &&
		r_reg.sel == fpc_pkg::FPC_SEL_FW_CALL;
	assign FW_FETCH    = !ONBOARD_MODE &&
		r_reg.sel == fpc_pkg::FPC_SEL_FW_FETCH;
endmodule : fpc_top

// File: inc/fpc_pkg.sv
// Constants and types shared by the flash programming control block.
package fpc_pkg;

	localparam logic [15:0] FPC_ADDR_MODE_CTL  = 16'hFFC4;
	localparam logic [15:0] FPC_ADDR_PROT_CMD  = 16'hFFC0;
	localparam logic [15:0] FPC_ADDR_PROT_STAT = 16'hFFC2;

	localparam logic [7:0]  FPC_PROT_KEY       = 8'hA5;
	localparam logic [7:0]  FPC_MODE_CTL_RESET = 8'h08;
	localparam logic [7:0]  FPC_PROT_STAT_RST  = 8'h00;
	localparam int          FPC_BIT_WED        = 3;
	localparam int          FPC_BIT_PIN        = 2;
	localparam int          FPC_BIT_PERR       = 0;

	localparam logic [1:0]  FPC_SEL_NORMAL     = 2'h0;
	localparam logic [1:0]  FPC_SEL_FW_CALL    = 2'h1;
	localparam logic [1:0]  FPC_SEL_BAD        = 2'h2;
	localparam logic [1:0]  FPC_SEL_FW_FETCH   = 2'h3;

	localparam logic [7:0]  FPC_CMD_RESET      = 8'h00;
	localparam logic [7:0]  FPC_CMD_VERIFY     = 8'h13;
	localparam logic [7:0]  FPC_CMD_ERASE      = 8'h20;
	localparam logic [7:0]  FPC_CMD_BLANK      = 8'h32;
	localparam logic [7:0]  FPC_CMD_HS_WRITE   = 8'h40;
	localparam logic [7:0]  FPC_CMD_SUCC_WRITE = 8'h44;
	localparam logic [7:0]  FPC_CMD_STATUS     = 8'h70;
	localparam logic [7:0]  FPC_CMD_OSC        = 8'h90;
	localparam logic [7:0]  FPC_CMD_ERASE_TIME = 8'h95;
	localparam logic [7:0]  FPC_CMD_WRITE_TIME = 8'h96;
	localparam logic [7:0]  FPC_CMD_BAUD       = 8'h9A;
	localparam logic [7:0]  FPC_CMD_SIGNATURE  = 8'hC0;

	localparam logic [7:0]  FPC_RSP_ACK        = 8'h06;
	localparam logic [7:0]  FPC_RSP_NAK        = 8'h15;
	localparam logic [7:0]  FPC_ERASED         = 8'hFF;

	localparam logic [7:0]  FPC_OSC_RESET      = 8'h01;
	localparam logic [7:0]  FPC_ETIME_RESET    = 8'h01;
	localparam logic [7:0]  FPC_WTIME_RESET    = 8'h01;
	localparam logic [2:0]  FPC_BAUD_RESET     = 3'h0;
	localparam logic [7:0]  FPC_BAUD_MAX       = 8'h05;
	localparam logic [1:0]  FPC_SIG_BYTES      = 2'h3;

	typedef enum logic [3:0] {
		FPC_IDLE, FPC_ARG, FPC_VERIFY, FPC_WDATA, FPC_WWAIT,
		FPC_WCHECK, FPC_EWAIT, FPC_ECLEAR, FPC_BLANK
	} fpc_state_t;

	typedef enum logic [1:0] {
		FPC_P_IDLE, FPC_P_KEY, FPC_P_VALUE, FPC_P_INVERSE
	} fpc_prot_t;

endpackage : fpc_pkg

// File: dv/fpc_top_props.sv
// Assertions on the ports of the flash programming control block.
module fpc_top_props (
	input wire logic        CLK_SYS,
	input wire logic        SYS_RST,
	input wire logic        RX_VALID,
	input wire logic        RX_READY,
	input wire logic        RSP_VALID,
	input wire logic        RSP_READY,
	input wire logic [7:0]  RSP_DATA,
	input wire logic [2:0]  BAUD_SEL,
	input wire logic        BUSY,
	input wire logic        ST_VALID,
	input wire logic [15:0] LD_ADDR,
	input wire logic [7:0]  LD_DATA,
	input wire logic        FW_ACTIVE,
	input wire logic        FLASH_MODE_PIN,
	input wire logic        ONBOARD_MODE,
	input wire logic        FLASH_WE_EN,
	input wire logic        FETCH_USER,
	input wire logic        FW_CALL_EN,
	input wire logic        FW_FETCH
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (SYS_RST);

	sequence quiet_s;
		(!RSP_VALID && !BUSY && !(RX_VALID && RX_READY))[*4];
	endsequence
	sequence held_s;
		RSP_VALID && !RSP_READY;
	endsequence
	sequence mc_read_s;
		$past(LD_ADDR) == fpc_pkg::FPC_ADDR_MODE_CTL && !$past(SYS_RST, 2);
	endsequence

	no_unasked_rsp_a: assert property (quiet_s |=> !RSP_VALID)
		else $error("response appeared without a request");
	rsp_hold_a: assert property (
		held_s |=> RSP_VALID && $stable(RSP_DATA))
		else $error("response byte dropped before it was taken");
	baud_range_a: assert property (BAUD_SEL <= 3'h5)
		else $error("baud index out of range");
	sel_decode_a: assert property (
		FETCH_USER != FW_FETCH && !(FW_CALL_EN && FW_FETCH))
		else $error("fetch select decode inconsistent");
	onboard_sel_a: assert property (
		ONBOARD_MODE && $past(ONBOARD_MODE) |->
		FETCH_USER && !FW_CALL_EN && !FW_FETCH)
		else $error("select field honoured in on-board mode");
	fw_fetch_a: assert property (
		$rose(FW_FETCH) |-> $past(FW_ACTIVE) || $past(ONBOARD_MODE))
		else $error("firmware fetch set without firmware");
	mode_bits_a: assert property (
		mc_read_s |-> LD_DATA[7:4] == 4'h0 &&
		LD_DATA[1:0] != fpc_pkg::FPC_SEL_BAD)
		else $error("mode control holds a forbidden value");
	pin_bit_a: assert property (
		mc_read_s |-> LD_DATA[2] == $past(FLASH_MODE_PIN, 2))
		else $error("pin level bit does not follow the pin");
	we_gate_a: assert property (
		mc_read_s ##0 !$past(ST_VALID) && !$past(SYS_RST) &&
		$past(FLASH_MODE_PIN) == $past(FLASH_MODE_PIN, 2) |->
		FLASH_WE_EN == (!LD_DATA[3] && LD_DATA[2]))
		else $error("write enable disagrees with mode control");
endmodule : fpc_top_props

bind fpc_top fpc_top_props i_props (.*);

// File: dv/fpc_prog_model.sv
// Behavioural flash programmer that sends frames and takes answers.
module fpc_prog_model (
	input  wire logic       clk,
	output logic            rx_valid,
	input  wire logic       rx_ready,
	output logic      [7:0] rx_data,
	output logic            rx_start,
	input  wire logic       rsp_valid,
	output logic            rsp_ready,
	input  wire logic [7:0] rsp_data
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		rx_valid  = 1'b0;
		rx_data   = 8'h00;
		rx_start  = 1'b0;
		rsp_ready = 1'b0;
	end

	// Every frame is opened here; the device only ever answers.
	task automatic send(input logic [7:0] q[$], input logic st);
		int n;
		@(posedge clk);
		foreach (q[i])
		begin
			rx_valid <= 1'b1;
			rx_data  <= q[i];
			rx_start <= (i == 0) && st;
			@(negedge clk);
			for (n = 0; n < 4000 && !rx_ready; n++)
				@(negedge clk);
			@(posedge clk);
		end
		rx_valid <= 1'b0;
		rx_data  <= ~rx_data;
		rx_start <= 1'b0;
	endtask : send

	task automatic recv(input int stall, output logic [7:0] b);
		int n;
		@(posedge clk);
		repeat (stall) @(posedge clk);
		rsp_ready <= 1'b1;
		@(negedge clk);
		for (n = 0; n < 4000 && !rsp_valid; n++)
			@(negedge clk);
		b = rsp_data;
		@(posedge clk);
		rsp_ready <= 1'b0;
	endtask : recv
endmodule : fpc_prog_model

// File: dv/fpc_top_tb.sv
// Self-checking bench for the flash programming control block.
module fpc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int          DEPTH = 16;
	localparam logic [23:0] SIG   = 24'h3C5A96; // Arbitrary value.
	localparam logic [15:0] MC    = fpc_pkg::FPC_ADDR_MODE_CTL;
	localparam logic [15:0] PS    = fpc_pkg::FPC_ADDR_PROT_STAT;
	localparam logic [7:0]  ACK   = fpc_pkg::FPC_RSP_ACK;
	localparam logic [7:0]  NAK   = fpc_pkg::FPC_RSP_NAK;
	localparam logic [7:0]  SETC [3] = '{fpc_pkg::FPC_CMD_OSC,
		fpc_pkg::FPC_CMD_ERASE_TIME, fpc_pkg::FPC_CMD_WRITE_TIME};
	logic        clk_sys, sys_rst, rx_valid, rx_ready, rx_start, rsp_valid;
	logic        rsp_ready, busy, st_valid, fw_active, pin, onboard, we_en;
	logic        fetch_user, fw_call, fw_fetch;
	logic [7:0]  rx_data, rsp_data, st_data, ld_data, r, d0, d1, d2, mc;
	logic [15:0] st_addr, ld_addr;
	logic [2:0]  baud_sel;
	logic [7:0]  mem [DEPTH];
	logic [7:0]  q [$];
	int          failures, check_count, seed = 32;

	fpc_top #(.FLASH_DEPTH(DEPTH), .SIG_CODE(SIG)) i_dut (
		.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .RX_VALID(rx_valid),
		.RX_READY(rx_ready), .RX_DATA(rx_data), .RX_START(rx_start),
		.RSP_VALID(rsp_valid), .RSP_READY(rsp_ready), .RSP_DATA(rsp_data),
		.BAUD_SEL(baud_sel), .BUSY(busy), .ST_VALID(st_valid),
		.ST_ADDR(st_addr), .ST_DATA(st_data), .LD_ADDR(ld_addr),
		.LD_DATA(ld_data), .FW_ACTIVE(fw_active), .FLASH_MODE_PIN(pin),
		.ONBOARD_MODE(onboard), .FLASH_WE_EN(we_en),
		.FETCH_USER(fetch_user), .FW_CALL_EN(fw_call), .FW_FETCH(fw_fetch)
	);
	fpc_prog_model i_prog (
		.clk(clk_sys), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_data(rx_data), .rx_start(rx_start), .rsp_valid(rsp_valid),
		.rsp_ready(rsp_ready), .rsp_data(rsp_data)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic summarize;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic cmd(input logic [7:0] c[$], input logic [7:0] e[$]);
		i_prog.send(c, 1'b1);
		foreach (e[k])
		begin
			i_prog.recv($unsigned($random(seed)) % 3, r);
			chk("response", e[k], r);
		end
	endtask : cmd

	task automatic vfy(input logic [7:0] e);
		q = '{fpc_pkg::FPC_CMD_VERIFY};
		foreach (mem[k])
			q.push_back(mem[k]);
		cmd(q, '{e});
	endtask : vfy

	task automatic st(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		st_valid <= 1'b1;
		st_addr  <= a;
		st_data  <= d;
	endtask : st

	// The last store is held for one more edge so it is taken before the strobe drops.
	task automatic pwr(input logic [7:0] v, input logic [7:0] w);
		st(fpc_pkg::FPC_ADDR_PROT_CMD, fpc_pkg::FPC_PROT_KEY);
		st(MC, v);
		st(MC, ~v);
		st(MC, w);
		@(posedge clk_sys);
		st_valid <= 1'b0;
	endtask : pwr

	task automatic rd(input logic [15:0] a);
		@(posedge clk_sys);
		ld_addr <= a;
		@(posedge clk_sys);
		@(negedge clk_sys);
		r = ld_data;
	endtask : rd

	initial
	begin
		#100us;
		failures++;
		summarize();
	end

	initial
	begin
		sys_rst   = 1'b1;
		st_valid  = 1'b0;
		st_addr   = 16'h0000;
		st_data   = 8'h00;
		ld_addr   = MC;
		fw_active = 1'b0;
		pin       = 1'b0;
		onboard   = 1'b0;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(MC);
		chk("mode_ctl", 8'h08, r);
		cmd('{fpc_pkg::FPC_CMD_STATUS}, '{ACK, 8'h00});
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		pin     <= 1'b1;
		onboard <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(MC);
		chk("mode_ctl", 8'h0C, r);
		chk("fetch_user", 8'h01, 8'(fetch_user));
		@(posedge clk_sys);
		onboard <= 1'b0;
		mc = 8'h05;
		pwr(mc, mc);
		rd(MC);
		chk("mode_ctl", {4'h0, mc[3], pin, mc[1:0]}, r);
		chk("fw_call", 8'h01, 8'(fw_call));
		chk("we_en", 8'h01, 8'(we_en));
		pwr(8'h08, 8'h00);
		rd(MC);
		chk("mode_ctl", {4'h0, mc[3], pin, mc[1:0]}, r);
		rd(PS);
		chk("prot_err", 8'h01, r);
		st(PS, 8'h00);
		pwr(8'h03, 8'h03);
		rd(PS);
		chk("prot_err", 8'h00, r);
		chk("fw_fetch", 8'h00, 8'(fw_fetch));
		fw_active <= 1'b1;
		pwr(8'h03, 8'h03);
		rd(MC);
		chk("fw_fetch", 8'h01, 8'(fw_fetch));
		@(posedge clk_sys);
		onboard <= 1'b1;
		rd(MC);
		chk("fw_fetch", 8'h00, 8'(fw_fetch));
		chk("fw_call", 8'h00, 8'(fw_call));
		onboard   <= 1'b0;
		fw_active <= 1'b0;
		pin       <= 1'b0;
		mc = 8'h00;
		pwr(mc, mc);
		rd(MC);
		chk("we_en", 8'h00, 8'(we_en));
		chk("fetch_user", 8'h01, 8'(fetch_user));
		pin <= 1'b1;
		i_prog.send('{8'h55}, 1'b0);
		i_prog.recv(0, r);
		chk("response", NAK, r);
		cmd('{8'hEE}, '{NAK});
		// A baud index of zero is refused, so the draw spans 1 to 5.
		d0 = 8'(1 + $unsigned($random(seed)) % 5);
		cmd('{fpc_pkg::FPC_CMD_BAUD, d0}, '{ACK});
		chk("baud_sel", d0, 8'(baud_sel));
		cmd('{fpc_pkg::FPC_CMD_BAUD, 8'h06}, '{NAK});
		foreach (SETC[k])
		begin
			cmd('{SETC[k], 8'h01}, '{ACK});
			cmd('{SETC[k], 8'h00}, '{NAK});
		end
		q = '{ACK, SIG[23:16], SIG[15:8], SIG[7:0]};
		cmd('{fpc_pkg::FPC_CMD_SIGNATURE}, q);
		cmd('{fpc_pkg::FPC_CMD_SUCC_WRITE, 8'h01, 8'h5A}, '{NAK});
		cmd('{fpc_pkg::FPC_CMD_ERASE}, '{ACK});
		foreach (mem[k])
			mem[k] = fpc_pkg::FPC_ERASED;
		cmd('{fpc_pkg::FPC_CMD_BLANK}, '{ACK});
		d0 = 8'($random(seed));
		d1 = 8'($random(seed));
		d2 = 8'($random(seed));
		q = '{fpc_pkg::FPC_CMD_HS_WRITE, 8'h00, 8'h04, 8'h02, d0, d1};
		cmd(q, '{ACK});
		mem[4] = d0;
		mem[5] = d1;
		cmd('{fpc_pkg::FPC_CMD_SUCC_WRITE, 8'h01, d2}, '{ACK});
		mem[6] = d2;
		cmd('{fpc_pkg::FPC_CMD_STATUS}, '{ACK, 8'h06});
		vfy(ACK);
		mem[0] = 8'h00;
		vfy(NAK);
		mem[0] = fpc_pkg::FPC_ERASED;
		cmd('{fpc_pkg::FPC_CMD_BLANK}, '{NAK});
		pwr(8'h08, 8'h08);
		q = '{fpc_pkg::FPC_CMD_HS_WRITE, 8'h00, 8'h00, 8'h01, 8'h00};
		cmd(q, '{NAK});
		vfy(ACK);
		i_prog.send('{fpc_pkg::FPC_CMD_HS_WRITE, 8'h00}, 1'b1);
		@(negedge clk_sys);
		chk("busy", 8'h01, 8'(busy));
		cmd('{fpc_pkg::FPC_CMD_RESET}, '{ACK});
		chk("busy", 8'h00, 8'(busy));
		summarize();
	end
endmodule : fpc_top_tb
